// ===== shared/pdc_pkg.sv
// Purpose: Constants for the port test and debug register bank
// Assumes: AXI4-Lite with 32-bit data and 12-bit byte addresses
// Notes:   Every register takes one aligned word; offsets are bytes
package pdc_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          NUM_PORTS       = 3;

  // Register byte offsets
  localparam logic [11:0] OFF_OPMODE      = 12'h098;
  localparam logic [11:0] OFF_HOLD        = 12'h324;
  localparam logic [11:0] OFF_IND0        = 12'h328;
  localparam logic [11:0] OFF_IND1        = 12'h32C;
  localparam logic [11:0] OFF_LINK_STATE  = 12'h33C;
  localparam logic [11:0] OFF_LINK_LAYER  = 12'h340;
  localparam logic [11:0] OFF_TL          = 12'h344;
  localparam logic [11:0] OFF_DBG_CTRL    = 12'h348;
  localparam logic [11:0] OFF_DBG_DATA    = 12'h34C;

  // Writable or readable bits of each writable register
  localparam logic [31:0] MASK_HOLD       = 32'h0007_0707;
  localparam logic [31:0] MASK_IND0       = 32'h0000_01FF;
  localparam logic [31:0] MASK_IND1       = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_TL         = 32'h0000_00FF;
  localparam logic [31:0] MASK_DBG_CTRL   = 32'h0000_01FF;
  localparam logic [31:0] MASK_OPMODE     = 32'h00FF_0000;

  // Field positions
  localparam int          HOLD_DIS_LSB    = 0;
  localparam int          HOLD_QUIET_LSB  = 8;
  localparam int          HOLD_RATE_LSB   = 16;
  localparam int          IND0_W          = 9;
  localparam int          DBG_MODE_LSB    = 0;
  localparam int          DBG_MODE_W      = 5;
  localparam int          DBG_PORT_LSB    = 5;
  localparam int          DBG_PORT_W      = 3;
  localparam int          DBG_START_BIT   = 8;
  localparam int          LL_ADAPT_ACK    = 4;
  localparam int          LL_FIX_DIS_DET  = 5;
  localparam int          OPMODE_CLK_LSB  = 16;
  localparam int          LINK_STATE_W    = 8;
  localparam int          LINK_LAYER_W    = 16;
  localparam int          TL_W            = 8;

  // Reset values
  localparam logic [31:0] RST_HOLD        = 32'h0000_0000;
  localparam logic [31:0] RST_IND0        = 32'h0000_0000;
  localparam logic [31:0] RST_IND1        = 32'h0000_0000;
  localparam logic [7:0]  RST_LINK_STATE  = 8'h04;
  localparam logic [15:0] RST_LINK_LAYER  = 16'h0004;
  localparam logic [31:0] RST_TL          = 32'h0000_0003;
  localparam logic [31:0] RST_DBG_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_DBG_DATA    = 32'h0000_0000;
  localparam logic [31:0] RST_OPMODE      = 32'h0000_0000;

  // Probe signal group holding the link training state machine
  localparam logic [4:0]  DBG_GRP_LTSSM   = 5'h00;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Cycles the strap synchroniser needs before its output means anything
  localparam logic [1:0]  SYNC_FILL       = 2'h3;

endpackage : pdc_pkg

// ===== tb/pdc_csr_bank_test.sv
// Purpose: Self-checking bench for the port test and debug register bank
// Assumes: AXI4-Lite master in this bench; upstream build of the bank
// Notes:   Bus tasks sample handshakes at the falling edge, act at rising
module pdc_csr_bank_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0, rst_b = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, debug_probe_in = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        eeprom_load_valid = 1'b0;
  logic [7:0]  eeprom_link_state = 8'h00;
  logic [15:0] eeprom_link_layer = 16'h0000;
  logic        clock_buffer_powerdown_strap = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        debug_probe_capture, clock_buffer_enable;
  logic [1:0]  bresp, rresp, ds_rresp;
  logic [31:0] rdata, indicator_field_1, ds_rdata;
  logic [4:0]  debug_probe_mode;
  logic [2:0]  debug_probe_port, port_disable_hold, port_quiet_hold;
  logic [2:0]  port_pattern_rate, ref_clock_out_enable;
  logic [8:0]  indicator_field_0;
  logic [7:0]  transaction_layer_tuning;
  int          err_count = 0;
  int          cmp_count = 0;

  pdc_csr_bank #(.IS_UPSTREAM(1'b1)) i_pdc_csr_bank
  (
    .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .eeprom_load_valid(eeprom_load_valid),
    .eeprom_link_state(eeprom_link_state),
    .eeprom_link_layer(eeprom_link_layer),
    .debug_probe_in(debug_probe_in), .debug_probe_mode(debug_probe_mode),
    .debug_probe_port(debug_probe_port),
    .debug_probe_capture(debug_probe_capture),
    .port_disable_hold(port_disable_hold), .port_quiet_hold(port_quiet_hold),
    .port_pattern_rate(port_pattern_rate),
    .indicator_field_0(indicator_field_0),
    .indicator_field_1(indicator_field_1),
    .transaction_layer_tuning(transaction_layer_tuning),
    .clock_buffer_powerdown_strap(clock_buffer_powerdown_strap),
    .clock_buffer_enable(clock_buffer_enable),
    .ref_clock_out_enable(ref_clock_out_enable)
  );

  // Downstream build follows the same bus traffic; only its read answer
  // is watched, to see debug control absent there
  pdc_csr_bank #(.IS_UPSTREAM(1'b0)) i_pdc_csr_bank_down
  (
    .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(), .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(ds_rdata),
    .rresp(ds_rresp), .rvalid(), .rready(rready),
    .eeprom_load_valid(eeprom_load_valid),
    .eeprom_link_state(eeprom_link_state),
    .eeprom_link_layer(eeprom_link_layer),
    .debug_probe_in(debug_probe_in), .debug_probe_mode(),
    .debug_probe_port(), .debug_probe_capture(),
    .port_disable_hold(), .port_quiet_hold(), .port_pattern_rate(),
    .indicator_field_0(), .indicator_field_1(),
    .transaction_layer_tuning(),
    .clock_buffer_powerdown_strap(clock_buffer_powerdown_strap),
    .clock_buffer_enable(), .ref_clock_out_enable()
  );

  always #2 clk = ~clk;

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // Strap is latched once per reset, so wait well past its settle time
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : do_reset

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    int   n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    tb = 1'b0;
    r = 2'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 100)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      n++;
    end
    chk("write handshake", 32'h1, {31'h0, tb});
    chk("write response", {30'h0, er}, {30'h0, r});
  endtask : axi_wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    int   n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0]  r;
    n = 0;
    tr = 1'b0;
    d = 32'h0;
    r = 2'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 100)
    begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
      n++;
    end
    chk("read handshake", 32'h1, {31'h0, tr});
    chk("read response", {30'h0, er}, {30'h0, r});
    chk("read data", exp, d);
  endtask : rd_chk

  task automatic test_reset_values;
    rd_chk(pdc_pkg::OFF_HOLD, 32'h0000_0000, 2'h0);
    rd_chk(pdc_pkg::OFF_LINK_STATE, 32'h0000_0004, 2'h0);
    rd_chk(pdc_pkg::OFF_LINK_LAYER, 32'h0000_0004, 2'h0);
    rd_chk(pdc_pkg::OFF_TL, 32'h0000_0003, 2'h0);
    rd_chk(pdc_pkg::OFF_IND1, 32'h0000_0000, 2'h0);
    chk("tuning out", 32'h3, {24'h0, transaction_layer_tuning});
    $display("test reset values done");
  endtask : test_reset_values

  task automatic test_port_hold;
    axi_wr(pdc_pkg::OFF_HOLD, 32'hFFFF_FFFF, 4'h1, 2'h0);
    rd_chk(pdc_pkg::OFF_HOLD, 32'h0000_0007, 2'h0);
    chk("disable out", 32'h7, {29'h0, port_disable_hold});
    chk("quiet out", 32'h0, {29'h0, port_quiet_hold});
    axi_wr(pdc_pkg::OFF_HOLD, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_HOLD, 32'h0007_0707, 2'h0);
    chk("quiet out", 32'h7, {29'h0, port_quiet_hold});
    chk("rate out", 32'h7, {29'h0, port_pattern_rate});
    axi_wr(pdc_pkg::OFF_HOLD, 32'h0001_0200, 4'hF, 2'h0);
    chk("disable out", 32'h0, {29'h0, port_disable_hold});
    chk("quiet out", 32'h2, {29'h0, port_quiet_hold});
    chk("rate out", 32'h1, {29'h0, port_pattern_rate});
    $display("test port hold done");
  endtask : test_port_hold

  task automatic test_tuning_regs;
    axi_wr(pdc_pkg::OFF_IND0, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_IND0, 32'h0000_01FF, 2'h0);
    chk("indicator 0", 32'h1FF, {23'h0, indicator_field_0});
    axi_wr(pdc_pkg::OFF_IND1, 32'h1122_3344, 4'hF, 2'h0);
    axi_wr(pdc_pkg::OFF_IND1, 32'hAABB_CCDD, 4'hA, 2'h0);
    rd_chk(pdc_pkg::OFF_IND1, 32'hAA22_CC44, 2'h0);
    chk("indicator 1", 32'hAA22_CC44, indicator_field_1);
    axi_wr(pdc_pkg::OFF_TL, 32'hFFFF_FF5A, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_TL, 32'h0000_005A, 2'h0);
    chk("tuning out", 32'h5A, {24'h0, transaction_layer_tuning});
    $display("test tuning registers done");
  endtask : test_tuning_regs

  task automatic test_status_load;
    axi_wr(pdc_pkg::OFF_LINK_STATE, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_LINK_STATE, 32'h0000_0004, 2'h0);
    axi_wr(pdc_pkg::OFF_LINK_LAYER, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_LINK_LAYER, 32'h0000_0004, 2'h0);
    eeprom_link_state <= 8'hC3;
    eeprom_link_layer <= 16'hA530;
    eeprom_load_valid <= 1'b1;
    @(posedge clk);
    eeprom_load_valid <= 1'b0;
    @(posedge clk);
    rd_chk(pdc_pkg::OFF_LINK_STATE, 32'h0000_00C3, 2'h0);
    rd_chk(pdc_pkg::OFF_LINK_LAYER, 32'h0000_A530, 2'h0);
    $display("test status load done");
  endtask : test_status_load

  task automatic test_debug_probe;
    debug_probe_in <= 32'hDEAD_BEEF;
    axi_wr(pdc_pkg::OFF_DBG_CTRL, 32'hFFFF_FFE3, 4'hF, 2'h0);
    chk("probe mode", 32'h03, {27'h0, debug_probe_mode});
    chk("probe port", 32'h7, {29'h0, debug_probe_port});
    chk("probe start", 32'h1, {31'h0, debug_probe_capture});
    rd_chk(pdc_pkg::OFF_DBG_CTRL, 32'h0000_01E3, 2'h0);
    chk("down resp", {30'h0, pdc_pkg::RESP_SLVERR}, {30'h0, ds_rresp});
    chk("down data", 32'h0, ds_rdata);
    rd_chk(pdc_pkg::OFF_DBG_DATA, 32'hDEAD_BEEF, 2'h0);
    axi_wr(pdc_pkg::OFF_DBG_CTRL, 32'h0000_0040, 4'hF, 2'h0);
    chk("probe mode", 32'h00, {27'h0, debug_probe_mode});
    chk("probe port", 32'h2, {29'h0, debug_probe_port});
    debug_probe_in <= 32'h1234_5678;
    repeat (3) @(posedge clk);
    rd_chk(pdc_pkg::OFF_DBG_DATA, 32'hDEAD_BEEF, 2'h0);
    axi_wr(pdc_pkg::OFF_DBG_DATA, 32'h0, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_DBG_DATA, 32'hDEAD_BEEF, 2'h0);
    $display("test debug probe done");
  endtask : test_debug_probe

  task automatic test_unmapped;
    axi_wr(12'h350, 32'hFFFF_FFFF, 4'hF, pdc_pkg::RESP_SLVERR);
    rd_chk(12'h350, 32'h0, pdc_pkg::RESP_SLVERR);
    axi_wr(12'h325, 32'hFFFF_FFFF, 4'hF, pdc_pkg::RESP_SLVERR);
    rd_chk(pdc_pkg::OFF_HOLD, 32'h0001_0200, 2'h0);
    $display("test unmapped done");
  endtask : test_unmapped

  task automatic test_clock_buffer;
    chk("buffer enable", 32'h1, {31'h0, clock_buffer_enable});
    chk("output enables", 32'h7, {29'h0, ref_clock_out_enable});
    axi_wr(pdc_pkg::OFF_OPMODE, 32'hFFF5_FFFF, 4'hF, 2'h0);
    rd_chk(pdc_pkg::OFF_OPMODE, 32'h00F5_0000, 2'h0);
    chk("output enables", 32'h2, {29'h0, ref_clock_out_enable});
    clock_buffer_powerdown_strap <= 1'b1;
    do_reset();
    chk("buffer enable", 32'h0, {31'h0, clock_buffer_enable});
    chk("output enables", 32'h0, {29'h0, ref_clock_out_enable});
    clock_buffer_powerdown_strap <= 1'b0;
    repeat (10) @(posedge clk);
    chk("buffer enable", 32'h0, {31'h0, clock_buffer_enable});
    $display("test clock buffer done");
  endtask : test_clock_buffer

  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end

  initial
  begin
    do_reset();
    test_reset_values();
    test_port_hold();
    test_tuning_regs();
    test_status_load();
    test_debug_probe();
    test_unmapped();
    test_clock_buffer();
    give_verdict();
  end

endmodule : pdc_csr_bank_test

// ===== verilog/pdc_csr_bank.sv
// Purpose: Port test, indicator, status and debug probe register bank
// Assumes: AXI4-Lite slave, 32-bit data, one outstanding read and write
// Notes:   Clock buffer enables are levels for the analog clock buffer
//
// Behaviour
// - Per-port disable bit 1 holds that port's training machine in quiet.
// - Per-port quiet bit 1 keeps training machine in quiet; resets zero.
// - Three test pattern rate bits, one per port, reset to zero.
// - Link state status is read-only, resets 04h, EEPROM load replaces it.
// - Link layer status read-only, resets 04h; bit4 ack policy, bit5 detect.
// - Five-bit mode select picks probe group; zero is link training group.
// - Three-bit port select picks monitored port in the group.
// - Writing start bit one begins capturing probe data.
// - Read-only 32-bit debug data returns captured probe content.
// - Debug control and data exist only on the upstream port.
// - Strap sampled low enables clock buffer and its three outputs.
// - Operation mode bits 18:16 disable individual clock outputs.
// - Strap sampled high disables buffer and all outputs.
//
// The AXI4-Lite register port was left to the implementer.
module pdc_csr_bank
#(
  parameter bit IS_UPSTREAM = 1'b1
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AXI4-Lite slave
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Status auto-load from serial EEPROM
  input  wire logic        eeprom_load_valid,
  input  wire logic [7:0]  eeprom_link_state,
  input  wire logic [15:0] eeprom_link_layer,
  // Debug probe
  input  wire logic [31:0] debug_probe_in,
  output logic [4:0]       debug_probe_mode,
  output logic [2:0]       debug_probe_port,
  output logic             debug_probe_capture,
  // Port control to the link training machines
  output logic [2:0]       port_disable_hold,
  output logic [2:0]       port_quiet_hold,
  output logic [2:0]       port_pattern_rate,
  output logic [8:0]       indicator_field_0,
  output logic [31:0]      indicator_field_1,
  output logic [7:0]       transaction_layer_tuning,
  // Reference clock buffer
  input  wire logic        clock_buffer_powerdown_strap,
  output logic             clock_buffer_enable,
  output logic [2:0]       ref_clock_out_enable
);

  logic [11:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_got;
  logic        w_got;
  logic [11:0] raddr_q;
  logic        wr_en;
  logic        wr_ok;
  logic [31:0] rd_word;

  logic [31:0] hold_reg;
  logic [31:0] ind0_reg;
  logic [31:0] ind1_reg;
  logic [7:0]  link_state;
  logic [15:0] link_layer;
  logic [31:0] tl_reg;
  logic [31:0] dbg_ctrl;
  logic [31:0] dbg_data;
  logic [31:0] opmode_reg;

  logic        strap_level;
  logic        strap_valid;
  logic        strap_taken;
  logic        strap_high;

  function automatic logic addr_ok(input logic [11:0] a);
    case (a)
      pdc_pkg::OFF_OPMODE,
      pdc_pkg::OFF_HOLD,
      pdc_pkg::OFF_IND0,
      pdc_pkg::OFF_IND1,
      pdc_pkg::OFF_LINK_STATE,
      pdc_pkg::OFF_LINK_LAYER,
      pdc_pkg::OFF_TL:         addr_ok = 1'b1;
      pdc_pkg::OFF_DBG_CTRL,
      pdc_pkg::OFF_DBG_DATA:   addr_ok = IS_UPSTREAM;
      default:                 addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  // Byte-lane merge; reserved bits are forced to zero
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = data[8*i +: 8];
    merge = r & mask;
  endfunction : merge

  assign wr_en = aw_got && w_got && !bvalid;
  assign wr_ok = wr_en && addr_ok(waddr_q);

  // Write address and data are taken in either order
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready <= 1'b1;
      aw_got  <= 1'b0;
      waddr_q <= 12'h000;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      aw_got  <= 1'b1;
      waddr_q <= awaddr;
    end
    else if (bvalid && bready)
    begin
      awready <= 1'b1;
      aw_got  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wready  <= 1'b1;
      w_got   <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready  <= 1'b0;
      w_got   <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    else if (bvalid && bready)
    begin
      wready <= 1'b1;
      w_got  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid <= 1'b0;
      bresp  <= pdc_pkg::RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid <= 1'b1;
      bresp  <= addr_ok(waddr_q) ? pdc_pkg::RESP_OKAY
                                 : pdc_pkg::RESP_SLVERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  // Read path answers one cycle after the address is taken
  always_comb
  begin
    case (araddr)
      pdc_pkg::OFF_OPMODE:     rd_word = opmode_reg;
      pdc_pkg::OFF_HOLD:       rd_word = hold_reg;
      pdc_pkg::OFF_IND0:       rd_word = ind0_reg;
      pdc_pkg::OFF_IND1:       rd_word = ind1_reg;
      pdc_pkg::OFF_LINK_STATE: rd_word = {24'h000000, link_state};
      pdc_pkg::OFF_LINK_LAYER: rd_word = {16'h0000, link_layer};
      pdc_pkg::OFF_TL:         rd_word = tl_reg;
      pdc_pkg::OFF_DBG_CTRL:   rd_word = dbg_ctrl;
      pdc_pkg::OFF_DBG_DATA:   rd_word = dbg_data;
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= pdc_pkg::RESP_OKAY;
      raddr_q <= 12'h000;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      raddr_q <= araddr;
      rdata   <= addr_ok(araddr) ? rd_word : 32'h0000_0000;
      rresp   <= addr_ok(araddr) ? pdc_pkg::RESP_OKAY
                                 : pdc_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // Port hold, quiet and pattern rate controls
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hold_reg <= pdc_pkg::RST_HOLD;
    else if (wr_ok && waddr_q == pdc_pkg::OFF_HOLD)
      hold_reg <= merge(hold_reg, wdata_q, wstrb_q,
                        pdc_pkg::MASK_HOLD);
  end

  assign port_disable_hold = hold_reg[pdc_pkg::HOLD_DIS_LSB +: 3];
  assign port_quiet_hold   = hold_reg[pdc_pkg::HOLD_QUIET_LSB +: 3];
  assign port_pattern_rate = hold_reg[pdc_pkg::HOLD_RATE_LSB +: 3];

  // Indicator and transaction layer tuning
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ind0_reg <= pdc_pkg::RST_IND0;
      ind1_reg <= pdc_pkg::RST_IND1;
      tl_reg   <= pdc_pkg::RST_TL;
    end
    else if (wr_ok)
    begin
      if (waddr_q == pdc_pkg::OFF_IND0)
        ind0_reg <= merge(ind0_reg, wdata_q, wstrb_q, pdc_pkg::MASK_IND0);
      if (waddr_q == pdc_pkg::OFF_IND1)
        ind1_reg <= merge(ind1_reg, wdata_q, wstrb_q, pdc_pkg::MASK_IND1);
      if (waddr_q == pdc_pkg::OFF_TL)
        tl_reg <= merge(tl_reg, wdata_q, wstrb_q, pdc_pkg::MASK_TL);
    end
  end

  assign indicator_field_0        = ind0_reg[pdc_pkg::IND0_W-1:0];
  assign indicator_field_1        = ind1_reg;
  assign transaction_layer_tuning = tl_reg[pdc_pkg::TL_W-1:0];

  // Read-only status; only the EEPROM auto-load may change it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_state <= pdc_pkg::RST_LINK_STATE;
      link_layer <= pdc_pkg::RST_LINK_LAYER;
    end
    else if (eeprom_load_valid)
    begin
      link_state <= eeprom_link_state;
      link_layer <= eeprom_link_layer;
    end
  end

  // Debug probe control and capture
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dbg_ctrl <= pdc_pkg::RST_DBG_CTRL;
    else if (wr_ok && waddr_q == pdc_pkg::OFF_DBG_CTRL)
      dbg_ctrl <= merge(dbg_ctrl, wdata_q, wstrb_q,
                        pdc_pkg::MASK_DBG_CTRL);
  end

  assign debug_probe_mode    = dbg_ctrl[pdc_pkg::DBG_MODE_LSB +: 5];
  assign debug_probe_port    = dbg_ctrl[pdc_pkg::DBG_PORT_LSB +: 3];
  assign debug_probe_capture = dbg_ctrl[pdc_pkg::DBG_START_BIT];

  // Capture runs every cycle while the start bit is set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dbg_data <= pdc_pkg::RST_DBG_DATA;
    else if (dbg_ctrl[pdc_pkg::DBG_START_BIT])
      dbg_data <= debug_probe_in;
  end

  // Clock buffer output disables
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      opmode_reg <= pdc_pkg::RST_OPMODE;
    else if (wr_ok && waddr_q == pdc_pkg::OFF_OPMODE)
      opmode_reg <= merge(opmode_reg, wdata_q, wstrb_q,
                          pdc_pkg::MASK_OPMODE);
  end

  pdc_strap_sync u_strap_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (clock_buffer_powerdown_strap),
    .level (strap_level),
    .valid (strap_valid)
  );

  // Strap is caught once, at the first settled sample after reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_taken <= 1'b0;
      strap_high  <= 1'b1;
    end
    else if (strap_valid && !strap_taken)
    begin
      strap_taken <= 1'b1;
      strap_high  <= strap_level;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clock_buffer_enable  <= 1'b0;
      ref_clock_out_enable <= 3'h0;
    end
    else
    begin
      clock_buffer_enable  <= strap_taken && !strap_high;
      ref_clock_out_enable <= {3{strap_taken && !strap_high}}
                            & ~opmode_reg[pdc_pkg::OPMODE_CLK_LSB +: 3];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_HOLD_WRITE:
    assert property (wr_en && waddr_q == pdc_pkg::OFF_HOLD && wstrb_q[0]
                     |=> port_disable_hold == $past(wdata_q[2:0]))
    else $error("port disable bits did not take the write");

  AST_QUIET_WRITE:
    assert property (wr_en && waddr_q == pdc_pkg::OFF_HOLD && wstrb_q[1]
                     |=> port_quiet_hold == $past(wdata_q[10:8]))
    else $error("port quiet bits did not take the write");

  AST_RATE_KEEP:
    assert property (!(wr_en && waddr_q == pdc_pkg::OFF_HOLD)
                     |=> $stable(port_pattern_rate))
    else $error("pattern rate changed without a write");

  AST_LINK_STATE_LOAD:
    assert property (eeprom_load_valid
                     |=> link_state == $past(eeprom_link_state))
    else $error("link state status did not take the auto-load");

  AST_LINK_LAYER_RO:
    assert property (!eeprom_load_valid ##1 !eeprom_load_valid
                     |-> $stable(link_layer))
    else $error("link layer status changed without an auto-load");

  AST_MODE_SEL:
    assert property (wr_ok && waddr_q == pdc_pkg::OFF_DBG_CTRL && wstrb_q[0]
                     |=> debug_probe_mode == $past(wdata_q[4:0]))
    else $error("debug mode select did not take the write");

  AST_PORT_SEL:
    assert property (wr_ok && waddr_q == pdc_pkg::OFF_DBG_CTRL && wstrb_q[0]
                     |=> debug_probe_port == $past(wdata_q[7:5]))
    else $error("debug port select did not take the write");

  AST_CAPTURE:
    assert property (debug_probe_capture
                     |=> dbg_data == $past(debug_probe_in))
    else $error("debug data not captured while started");

  AST_DATA_READ:
    assert property (arvalid && arready && araddr == pdc_pkg::OFF_DBG_DATA
                     && IS_UPSTREAM |=> rvalid && rdata == $past(dbg_data))
    else $error("debug data read returned wrong value");

  AST_DOWNSTREAM_DBG:
    assert property (arvalid && arready && !IS_UPSTREAM
                     && araddr == pdc_pkg::OFF_DBG_CTRL
                     |=> rresp == pdc_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("debug control visible on a downstream port");

  AST_BUF_ON:
    assert property (strap_taken && !strap_high
                     |=> clock_buffer_enable)
    else $error("clock buffer not enabled with strap low");

  AST_OUT_DISABLE:
    assert property (opmode_reg[pdc_pkg::OPMODE_CLK_LSB]
                     |=> !ref_clock_out_enable[0])
    else $error("clock output 0 on while disabled");

  AST_BUF_OFF:
    assert property (strap_high
                     |=> !clock_buffer_enable && ref_clock_out_enable == 3'h0)
    else $error("clock buffer on with strap high");

  AST_RSVD_ZERO:
    assert property (rvalid && raddr_q == pdc_pkg::OFF_HOLD
                     |-> rdata[7:3] == 5'h00 && rdata[31:19] == 13'h0000)
    else $error("reserved bits of hold register read non-zero");

endmodule : pdc_csr_bank

// ===== verilog/pdc_strap_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a strap pin
// Assumes: Strap is quasi-static; one clock domain
// Notes:   level changes only once stages two and three agree
module pdc_strap_sync
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level,
  output logic      valid
);

  logic       s1;
  logic       s2;
  logic       s3;
  logic [1:0] fill;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fill <= 2'h0;
    else if (fill != pdc_pkg::SYNC_FILL)
      fill <= fill + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      level <= 1'b0;
      valid <= 1'b0;
    end
    else if (fill == pdc_pkg::SYNC_FILL && s2 == s3)
    begin
      level <= s3;
      valid <= 1'b1;
    end
  end

endmodule : pdc_strap_sync
